// [rtl/iacd_pkg.sv]
/*
 auxiliary command decoder package: register offsets, command codes,
 field positions, reset values and bus carrier structs.
 assumes a 32-bit APB slave with one register per aligned word.
*/
package iacd_pkg;
   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] IACD_AUX_MODE_OFS = 8'h00; // command write
   localparam logic [7:0] IACD_AUX_CFG_B_OFS = 8'h04; // config b
   localparam logic [7:0] IACD_STATUS_OFS = 8'h08; // local msg state
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int IACD_CMD_BIT3_POS = 3; // command bit 3
   localparam int IACD_ISS_POS = 4; // status source select in cfg b
   // ----------------------------------------------------------------
   // command codes, bit 3 masked out in the base codes; VS, TCSE and LTNC carry it set
   // ----------------------------------------------------------------
   localparam logic [4:0] IACD_CMD_PPF = 5'h01; // parallel poll flag
   localparam logic [4:0] IACD_CMD_RTL = 5'h05; // return to local
   localparam logic [4:0] IACD_CMD_SEND_END_IDENTIFY_CMD = 5'h06; // send end or identify
   localparam logic [4:0] IACD_CMD_NVS = 5'h07; // non-valid secondary
   localparam logic [4:0] IACD_CMD_VS = 5'h0F; // valid secondary
   localparam logic [4:0] IACD_CMD_GTS = 5'h10; // go to standby
   localparam logic [4:0] IACD_CMD_TCA = 5'h11; // take ctl async
   localparam logic [4:0] IACD_CMD_TCS = 5'h12; // take ctl sync
   localparam logic [4:0] IACD_CMD_TCSE = 5'h1A; // take ctl sync on end
   localparam logic [4:0] IACD_CMD_LTN = 5'h13; // listen
   localparam logic [4:0] IACD_CMD_LTNC = 5'h1B; // listen continuous
   localparam logic [4:0] IACD_CMD_MASK = 5'h17; // clears bit 3
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [4:0] IACD_CFG_B_RST = 5'h00; // config b reset
   localparam logic [31:0] IACD_RDATA_RST = 32'h0000_0000; // read data
   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } iacd_apb_req_type;

   // interface function states reported by the bus interface controller
   typedef struct packed {
      logic talker_addressed_flag; // addressed as talker
      logic cacs; // controller active state
      logic csbs; // controller standby state
      logic csws; // controller sync wait state
      logic lids; // listener idle state
      logic anrs_entry; // one-cycle pulse on entering anrs
      logic end_rx; // end received with last byte
      logic end_gen; // end message generated
      logic srqs; // service request state
      logic addr_hold; // dac held off by address pass-through
      logic dcas_hold; // device clear active in holdoff
      logic dtas_hold; // device trigger active in holdoff
      logic byte_sent; // one-cycle pulse: source handshake done
   } iacd_ifc_state_type;
endpackage

// [rtl/iacd_apb_slave.sv]
/*
 apb slave for the auxiliary command decoder.
 assumes a single-clock apb master; answers with pready in the access
 cycle, flags unmapped addresses with pslverr.
*/
`timescale 1ns/10ps
`default_nettype none
module iacd_apb_slave
   import iacd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire iacd_apb_req_type apb_req,
   input wire logic [31:0] status_word,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   output logic cmd_wr,
   output logic [4:0] cmd_code,
   output logic [4:0] cfg_b
);
   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic access; // access phase
   logic hit_mode; // aux mode register
   logic hit_cfg; // aux config b
   logic hit_stat; // status
   logic [4:0] cfg_b_r; // config b storage
   logic [4:0] cfg_b_nxt;
   logic [31:0] prdata_r; // registered read data
   logic [31:0] prdata_nxt;

   assign access = apb_req.psel & apb_req.penable;
   assign hit_mode = apb_req.paddr == IACD_AUX_MODE_OFS;
   assign hit_cfg = apb_req.paddr == IACD_AUX_CFG_B_OFS;
   assign hit_stat = apb_req.paddr == IACD_STATUS_OFS;

   // zero wait states; error on unmapped word
   assign pready = access;
   assign pslverr = access & ~(hit_mode | hit_cfg | hit_stat);
   assign cmd_wr = access & apb_req.pwrite & hit_mode;
   assign cmd_code = apb_req.pwdata[4:0];
   assign cfg_b = cfg_b_r;
   assign prdata = prdata_r;

   // next config and read data; read data prepared in setup cycle
   always_comb begin
      cfg_b_nxt = cfg_b_r;
      prdata_nxt = prdata_r;
      if (access & apb_req.pwrite & hit_cfg) begin
         cfg_b_nxt = apb_req.pwdata[4:0];
      end
      if (apb_req.psel & ~apb_req.penable & ~apb_req.pwrite) begin
         if (hit_cfg) begin
            prdata_nxt = {27'h0000000, cfg_b_r};
         end else if (hit_stat) begin
            prdata_nxt = status_word;
         end else begin
            prdata_nxt = IACD_RDATA_RST; // mode register reads zero
         end
      end
   end

   // register stage
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg_b_r <= IACD_CFG_B_RST;
         prdata_r <= IACD_RDATA_RST;
      end else begin
         cfg_b_r <= cfg_b_nxt;
         prdata_r <= prdata_nxt;
      end
   end
endmodule
`default_nettype wire

// [rtl/iacd_decoder.sv]
/*
 auxiliary command decoder top: turns five-bit auxiliary commands into
 the local messages of an ieee 488 talker/listener/controller.
 assumes interface function states arrive synchronous to ref_clk from
 the bus interface controller, and the host writes commands over apb.
*/
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - rtl pulses if bit3 zero, else holds
// - eoi with next byte, drop after handshake
// - send eoi ignored unless talker addressed
// - non-valid secondary releases dac as osa
// - valid secondary releases dac as msa
// - valid secondary also releases dcas/dtas holdoff
// - parallel poll flag loads command bit3
// - ist from flag or srqs per select
// - gts set in any state, effective in cacs, cleared leaving cacs
// - tca is a single pulse
// - tcs set, effective in csbs or csws
// - tcs cleared on entering cacs
// - tcs on end armed until end in csbs
// - listen pulses ltn
// - continuous listen pulses ltn, enters mode
// - continuous: rdy unless end, no data-in
// - continuous ends on listen or lids
module iacd_decoder
   import iacd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   input wire iacd_ifc_state_type ifc,
   input wire logic byte_rx,
   output logic rtl_msg,
   output logic eoi_out,
   output logic eoi_oe,
   output logic osa_release,
   output logic msa_release,
   output logic dac_release,
   output logic ist_msg,
   output logic gts_msg,
   output logic tca_msg,
   output logic tcs_msg,
   output logic ltn_msg,
   output logic cont_mode,
   output logic rdy_msg,
   output logic rfd_hold,
   output logic data_in_flag
);
   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   iacd_apb_req_type apb_req; // bundled request
   logic cmd_wr; // command write strobe
   logic [4:0] cmd_code; // written code
   logic [4:0] cfg_b; // aux_config_b
   logic [31:0] status_word; // readable state
   logic [4:0] cmd_base; // code with bit 3 cleared
   logic command_bit3; // value bit of the code

   assign apb_req = '{psel: psel, penable: penable, pwrite: pwrite,
                      paddr: paddr, pwdata: pwdata};

   iacd_apb_slave u_apb (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .apb_req(apb_req),
      .status_word(status_word),
      .pready(pready),
      .pslverr(pslverr),
      .prdata(prdata),
      .cmd_wr(cmd_wr),
      .cmd_code(cmd_code),
      .cfg_b(cfg_b)
   );

   assign cmd_base = cmd_code & IACD_CMD_MASK;
   assign command_bit3 = cmd_code[IACD_CMD_BIT3_POS];

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic rtl_r, rtl_nxt; // rtl level or pulse
   logic rtl_hold_r, rtl_hold_nxt; // rtl held set
   logic send_end_identify_cmd_arm_r, send_end_identify_cmd_arm_nxt; // eoi armed for next byte
   logic eoi_r, eoi_nxt; // eoi driven
   logic osa_r, osa_nxt; // osa release pulse
   logic msa_r, msa_nxt; // msa release pulse
   logic dac_r, dac_nxt; // dac release pulse
   logic ppf_r, ppf_nxt; // parallel poll flag
   logic gts_req_r, gts_req_nxt; // gts requested
   logic tca_r, tca_nxt; // tca pulse
   logic tcs_r, tcs_nxt; // tcs local message
   logic tcse_r, tcse_nxt; // tcs armed on end
   logic ltn_r, ltn_nxt; // ltn pulse
   logic cont_r, cont_nxt; // continuous mode
   logic rdy_r, rdy_nxt; // rdy pulse
   logic rfdh_r, rfdh_nxt; // rfd holdoff
   logic di_r, di_nxt; // data in flag
   logic cacs_q, lids_q; // cacs and lids last cycle
   logic cacs_entry; // entering cacs

   assign cacs_entry = ifc.cacs & ~cacs_q;

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      rtl_hold_nxt = rtl_hold_r;
      rtl_nxt = rtl_hold_r;
      send_end_identify_cmd_arm_nxt = send_end_identify_cmd_arm_r;
      eoi_nxt = eoi_r;
      osa_nxt = 1'b0;
      msa_nxt = 1'b0;
      dac_nxt = 1'b0;
      ppf_nxt = ppf_r;
      gts_req_nxt = gts_req_r;
      tca_nxt = 1'b0;
      tcs_nxt = tcs_r;
      tcse_nxt = tcse_r;
      ltn_nxt = 1'b0;
      cont_nxt = cont_r;
      rdy_nxt = 1'b0;
      rfdh_nxt = rfdh_r;
      di_nxt = di_r;
      // eoi rides on the next byte, dropped when its handshake ends
      if (send_end_identify_cmd_arm_r & ifc.byte_sent) begin
         send_end_identify_cmd_arm_nxt = 1'b0;
         eoi_nxt = 1'b0;
      end
      // gts only while in cacs; leaving cacs drops the request
      if (cacs_q & ~ifc.cacs) begin
         gts_req_nxt = 1'b0;
      end
      // tcs on end fires on end generated in standby
      if (tcse_r & ifc.end_gen & ifc.csbs) begin
         tcs_nxt = 1'b1;
         tcse_nxt = 1'b0;
      end
      if (cacs_entry) begin
         tcs_nxt = 1'b0;
         tcse_nxt = 1'b0;
      end
      // continuous listening handshake
      if (cont_r & ifc.anrs_entry) begin
         if (ifc.end_rx) begin
            rfdh_nxt = 1'b1;
         end else begin
            rdy_nxt = 1'b1;
         end
      end
      if (byte_rx & ~cont_r) begin
         di_nxt = 1'b1;
      end
      if (ifc.lids & ~lids_q) begin
         cont_nxt = 1'b0;
         rfdh_nxt = 1'b0;
      end
      // command decode; upper bits assumed zero by the host
      if (cmd_wr) begin
         case (cmd_base)
            IACD_CMD_RTL: begin
               rtl_nxt = 1'b1;
               rtl_hold_nxt = command_bit3;
            end
            IACD_CMD_PPF: begin
               ppf_nxt = command_bit3;
            end
            IACD_CMD_SEND_END_IDENTIFY_CMD: begin
               if (!command_bit3 && ifc.talker_addressed_flag) begin
                  send_end_identify_cmd_arm_nxt = 1'b1;
                  eoi_nxt = 1'b1;
               end
            end
            IACD_CMD_NVS: begin
               if (!command_bit3 && ifc.addr_hold) begin
                  osa_nxt = 1'b1;
                  dac_nxt = 1'b1;
               end else if (command_bit3 && (ifc.addr_hold
                            || ifc.dcas_hold || ifc.dtas_hold)) begin
                  msa_nxt = ifc.addr_hold;
                  dac_nxt = 1'b1;
               end
            end
            IACD_CMD_GTS: begin
               if (!command_bit3) begin
                  gts_req_nxt = 1'b1;
               end
            end
            IACD_CMD_TCA: begin
               if (!command_bit3) begin
                  tca_nxt = 1'b1;
               end
            end
            IACD_CMD_TCS: begin
               if (command_bit3) begin
                  tcse_nxt = 1'b1;
               end else begin
                  tcs_nxt = 1'b1;
               end
            end
            IACD_CMD_LTN: begin
               ltn_nxt = 1'b1;
               cont_nxt = command_bit3;
               if (!command_bit3) begin
                  rfdh_nxt = 1'b0;
               end
            end
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rtl_r <= 1'b0;
         rtl_hold_r <= 1'b0;
         send_end_identify_cmd_arm_r <= 1'b0;
         eoi_r <= 1'b0;
         osa_r <= 1'b0;
         msa_r <= 1'b0;
         dac_r <= 1'b0;
         ppf_r <= 1'b0;
         gts_req_r <= 1'b0;
         tca_r <= 1'b0;
         tcs_r <= 1'b0;
         tcse_r <= 1'b0;
         ltn_r <= 1'b0;
         cont_r <= 1'b0;
         rdy_r <= 1'b0;
         rfdh_r <= 1'b0;
         di_r <= 1'b0;
         cacs_q <= 1'b0;
         lids_q <= 1'b1; // idle after reset, no false entry
      end else begin
         rtl_r <= rtl_nxt;
         rtl_hold_r <= rtl_hold_nxt;
         send_end_identify_cmd_arm_r <= send_end_identify_cmd_arm_nxt;
         eoi_r <= eoi_nxt;
         osa_r <= osa_nxt;
         msa_r <= msa_nxt;
         dac_r <= dac_nxt;
         ppf_r <= ppf_nxt;
         gts_req_r <= gts_req_nxt;
         tca_r <= tca_nxt;
         tcs_r <= tcs_nxt;
         tcse_r <= tcse_nxt;
         ltn_r <= ltn_nxt;
         cont_r <= cont_nxt;
         rdy_r <= rdy_nxt;
         rfdh_r <= rfdh_nxt;
         di_r <= di_nxt;
         cacs_q <= ifc.cacs;
         lids_q <= ifc.lids;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rtl_msg = rtl_r;
   assign eoi_out = eoi_r;
   assign eoi_oe = eoi_r;
   assign osa_release = osa_r;
   assign msa_release = msa_r;
   assign dac_release = dac_r;
   assign ist_msg = cfg_b[IACD_ISS_POS] ? ifc.srqs : ppf_r;
   assign gts_msg = gts_req_r & ifc.cacs;
   assign tca_msg = tca_r;
   assign tcs_msg = tcs_r & (ifc.csbs | ifc.csws);
   assign ltn_msg = ltn_r;
   assign cont_mode = cont_r;
   assign rdy_msg = rdy_r;
   assign rfd_hold = rfdh_r;
   assign data_in_flag = di_r;
   assign status_word = {17'h00000, cfg_b[IACD_ISS_POS], di_r, rfdh_r,
                         cont_r, tcse_r, tcs_r, gts_req_r, ppf_r,
                         send_end_identify_cmd_arm_r, eoi_r, rtl_hold_r, rtl_r,
                         ifc.talker_addressed_flag, ifc.cacs, ist_msg};

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_rtl_pulse_one: assert property (
      cmd_wr && cmd_code == IACD_CMD_RTL |=> rtl_msg ##1 !rtl_msg)
      else $error("rtl pulse not one cycle");
   a_send_end_identify_cmd_needs_ta: assert property (
      cmd_wr && cmd_code == IACD_CMD_SEND_END_IDENTIFY_CMD && !ifc.talker_addressed_flag
      && !eoi_r |=> !eoi_out)
      else $error("eoi set while not talker");
   a_eoi_drops_sent: assert property (
      eoi_r && ifc.byte_sent && !cmd_wr |=> !eoi_out)
      else $error("eoi stayed after handshake");
   a_osa_dac_pair: assert property (
      osa_release |-> dac_release)
      else $error("osa without dac release");
   a_ppf_loads_bit: assert property (
      cmd_wr && cmd_base == IACD_CMD_PPF && !cfg_b[IACD_ISS_POS]
      ##1 !cfg_b[IACD_ISS_POS] |-> ist_msg == $past(command_bit3))
      else $error("ist not equal to flag value");
   a_gts_only_cacs: assert property (
      gts_msg |-> ifc.cacs)
      else $error("gts outside cacs");
   a_tcs_clear_cacs: assert property (
      cacs_entry && !cmd_wr |=> !tcs_r)
      else $error("tcs survived cacs entry");
   a_tca_single: assert property (
      tca_msg && !$past(cmd_wr) |-> 0)
      else $error("tca without command");
   a_ltn_cont: assert property (
      cmd_wr && cmd_code == IACD_CMD_LTNC && !ifc.lids
      |=> ltn_msg && cont_mode)
      else $error("continuous listen not entered");
   a_cont_leave: assert property (
      ifc.lids && !lids_q && !cmd_wr |=> !cont_mode)
      else $error("continuous mode survived lids");
   a_di_blocked: assert property (
      cont_r && !di_r |=> !data_in_flag)
      else $error("data in set in continuous mode");
   c_send_end_identify_cmd_sent: cover property (eoi_r ##[1:20] !eoi_r);
   c_rtl_hold: cover property (rtl_hold_r ##1 !rtl_hold_r);
   c_tcs_end: cover property (tcse_r ##1 tcs_r);
   c_cont_rdy: cover property (cont_r && rdy_r);
endmodule
`default_nettype wire

// [dv/iacd_ctl_model.sv]
/*
 far-side model: controller, talker and listener states that the
 bus interface controller reports to the auxiliary command decoder.
 assumes the ref_clk domain and bench strobes driven at rising edges.
*/
`timescale 1ns/10ps
`default_nettype none
module iacd_ctl_model
   import iacd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic gts_msg,
   input wire logic tca_msg,
   input wire logic tcs_msg,
   input wire logic ltn_msg,
   input wire logic eoi_out,
   input wire logic dac_release,
   input wire logic talk,
   input wire logic srq,
   input wire logic hold_apt,
   input wire logic hold_dc,
   input wire logic send_req,
   input wire logic recv_req,
   input wire logic recv_end,
   input wire logic unlisten,
   output var iacd_ifc_state_type ifc,
   output logic byte_rx
);
   // ----------------------------------------------------------------
   // controller, holdoff and listener state
   // ----------------------------------------------------------------
   logic [1:0] st_r; // 0 idle, 1 active, 2 standby, 3 sync wait
   logic hold_r, dch_r, lsn_r, endg_r, endr_r, sent_r, rx_r;

   // controller state moves on the decoder's local messages; sync wait returns to active a cycle later
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         {st_r, hold_r, dch_r, lsn_r, endg_r, endr_r, sent_r} <= 8'h00;
         rx_r <= 1'b0;
      end else begin
         if (tca_msg) begin
            st_r <= 2'h1;
         end else if (st_r == 2'h1 && gts_msg) begin
            st_r <= 2'h2;
         end else if (st_r == 2'h2 && tcs_msg) begin
            st_r <= 2'h3;
         end else if (st_r == 2'h3) begin
            st_r <= 2'h1;
         end
         hold_r <= hold_apt | (hold_r & ~dac_release);
         dch_r <= hold_dc | (dch_r & ~dac_release);
         lsn_r <= ltn_msg | (lsn_r & ~unlisten);
         sent_r <= send_req; // handshake done one cycle after request
         endg_r <= (sent_r & eoi_out) | (endg_r & (st_r == 2'h2));
         rx_r <= recv_req;
         if (recv_req) begin
            endr_r <= recv_end; // end flag rides with the byte
         end
      end
   end

   // report the states as levels, handshake events as pulses
   always_comb begin
      ifc.talker_addressed_flag = talk;
      ifc.cacs = (st_r == 2'h1);
      ifc.csbs = (st_r == 2'h2);
      ifc.csws = (st_r == 2'h3);
      ifc.lids = ~lsn_r;
      ifc.anrs_entry = rx_r;
      ifc.end_rx = endr_r;
      ifc.end_gen = endg_r;
      ifc.srqs = srq;
      ifc.addr_hold = hold_r;
      ifc.dcas_hold = dch_r;
      ifc.dtas_hold = 1'b0; // trigger holdoff not modelled
      ifc.byte_sent = sent_r;
   end
   assign byte_rx = rx_r;
endmodule
`default_nettype wire

// [dv/tb_ieee488_aux_command_decoder.sv]
/*
 self-checking bench for the auxiliary command decoder.
 assumes the far-side model supplies interface states; apb master here.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_ieee488_aux_command_decoder
   import iacd_pkg::*;
;
   typedef struct packed {
      logic [4:0] code;
      logic [4:0] e1; // {rtl, tca, ltn, cont, ist} cycle after
      logic [4:0] e2; // same, one cycle later
   } iacd_row_type;
   iacd_row_type rows [9] = '{'{5'h05, 5'h10, 5'h00},
      '{5'h0D, 5'h10, 5'h10}, '{5'h05, 5'h10, 5'h00},
      '{5'h13, 5'h04, 5'h00}, '{5'h1B, 5'h06, 5'h02},
      '{5'h13, 5'h04, 5'h00}, '{5'h09, 5'h01, 5'h01},
      '{5'h01, 5'h00, 5'h00}, '{5'h11, 5'h08, 5'h00}};
   logic ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, byte_rx, err_r, eoi_seen = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   iacd_ifc_state_type ifc;
   logic rtl_msg, eoi_out, eoi_oe, osa_release, msa_release, dac_release;
   logic ist_msg, gts_msg, tca_msg, tcs_msg, ltn_msg, cont_mode, rdy_msg;
   logic rfd_hold, data_in_flag;
   logic talk = 1'b0, srq = 1'b0, hold_apt = 1'b0, hold_dc = 1'b0;
   logic send_req = 1'b0, recv_req = 1'b0, recv_end = 1'b0;
   logic unlisten = 1'b0;
   int err_total = 0, cmp_count = 0, cyc = 0, tcs_cnt = 0, rdy_cnt = 0;
   int i, t;

   always #2.5 ref_clk = ~ref_clk;

   iacd_decoder i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .pslverr(pslverr), .prdata(prdata), .ifc(ifc),
      .byte_rx(byte_rx), .rtl_msg(rtl_msg), .eoi_out(eoi_out),
      .eoi_oe(eoi_oe), .osa_release(osa_release),
      .msa_release(msa_release), .dac_release(dac_release),
      .ist_msg(ist_msg), .gts_msg(gts_msg), .tca_msg(tca_msg),
      .tcs_msg(tcs_msg), .ltn_msg(ltn_msg), .cont_mode(cont_mode),
      .rdy_msg(rdy_msg), .rfd_hold(rfd_hold), .data_in_flag(data_in_flag));
   iacd_ctl_model i_bus (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .gts_msg(gts_msg), .tca_msg(tca_msg), .tcs_msg(tcs_msg),
      .ltn_msg(ltn_msg), .eoi_out(eoi_out), .dac_release(dac_release),
      .talk(talk), .srq(srq), .hold_apt(hold_apt), .hold_dc(hold_dc),
      .send_req(send_req), .recv_req(recv_req), .recv_end(recv_end),
      .unlisten(unlisten), .ifc(ifc), .byte_rx(byte_rx));

   // ----------------------------------------------------------------
   // checking and reporting
   // ----------------------------------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task close_out;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // event counters, eoi seen with the completed byte, hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (ifc.byte_sent === 1'b1) eoi_seen <= eoi_out;
      if (tcs_msg === 1'b1) tcs_cnt <= tcs_cnt + 1;
      if (rdy_msg === 1'b1) rdy_cnt <= rdy_cnt + 1;
      if (cyc == 6000) begin
         err_total++;
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // bus and stimulus tasks
   // ----------------------------------------------------------------
   // one apb transfer, held until pready is sampled high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      // only pready or the bench timeout ends this wait
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err_r = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task cmd(input logic [4:0] c);
      apb(1'b1, IACD_AUX_MODE_OFS, {27'h0, c});
      #1;
   endtask
   task wait_cacs(input logic lvl);
      int n;
      n = 0;
      while (ifc.cacs !== lvl && n < 20) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      check(ifc.cacs, lvl);
   endtask
   // arm a holdoff, issue a secondary command, compare release pulses
   task sec(input logic [4:0] c, input logic [1:0] h,
            input logic [2:0] m, input logic [2:0] e);
      @(posedge ref_clk);
      hold_apt <= h[0];
      hold_dc <= h[1];
      @(posedge ref_clk);
      hold_apt <= 1'b0;
      hold_dc <= 1'b0;
      cmd(c);
      check({osa_release, msa_release, dac_release} & m, e);
   endtask
   // one received byte, then a short window for the ready pulse
   task rx(input logic e);
      @(posedge ref_clk);
      recv_req <= 1'b1;
      recv_end <= e;
      @(posedge ref_clk);
      recv_req <= 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      #1;
      check({rtl_msg, eoi_out, tca_msg, ltn_msg, cont_mode, rdy_msg}, 0);
      apb(1'b0, IACD_STATUS_OFS, 32'h0);
      check(rd, 32'h0000_0000);
      apb(1'b0, 8'h0C, 32'h0); // unmapped word
      check(err_r, 1'b1);
      check(rd, 32'h0000_0000);
      for (i = 0; i < 9; i++) begin
         cmd(rows[i].code);
         check({rtl_msg, tca_msg, ltn_msg, cont_mode, ist_msg},
               rows[i].e1);
         @(posedge ref_clk);
         #1;
         check({rtl_msg, tca_msg, ltn_msg, cont_mode, ist_msg},
               rows[i].e2);
      end
      // status source: service request drives ist
      apb(1'b1, IACD_AUX_CFG_B_OFS, 32'h0000_0010);
      srq <= 1'b1;
      @(posedge ref_clk);
      #1 check(ist_msg, 1'b1);
      @(posedge ref_clk);
      srq <= 1'b0;
      #1 check(ist_msg, 1'b0);
      apb(1'b1, IACD_AUX_CFG_B_OFS, 32'h0);
      // controller active after tca: tcs waits, gts then hands over
      cmd(IACD_CMD_TCS);
      check(tcs_msg, 1'b0);
      t = tcs_cnt;
      cmd(IACD_CMD_GTS);
      check(gts_msg, 1'b1);
      wait_cacs(1'b0);
      check(gts_msg, 1'b0);
      wait_cacs(1'b1);
      check({tcs_cnt != t, tcs_msg}, 2'b10);
      apb(1'b0, IACD_STATUS_OFS, 32'h0);
      check(rd[9:8], 2'b00);
      // standby: take control on end, send eoi refused then accepted
      cmd(IACD_CMD_GTS);
      wait_cacs(1'b0);
      t = tcs_cnt;
      cmd(IACD_CMD_TCSE);
      cmd(IACD_CMD_SEND_END_IDENTIFY_CMD);
      apb(1'b0, IACD_STATUS_OFS, 32'h0);
      check({rd[10], rd[6], eoi_out}, 3'b100);
      talk <= 1'b1;
      cmd(IACD_CMD_SEND_END_IDENTIFY_CMD);
      apb(1'b0, IACD_STATUS_OFS, 32'h0);
      check({rd[6], tcs_cnt == t}, 2'b11);
      send_req <= 1'b1;
      @(posedge ref_clk);
      send_req <= 1'b0;
      wait_cacs(1'b1);
      check({eoi_seen, eoi_out, eoi_oe}, 3'b100);
      check({tcs_cnt != t, tcs_msg}, 2'b10);
      // secondary address releases
      sec(IACD_CMD_NVS, 2'b01, 3'b111, 3'b101);
      sec(IACD_CMD_VS, 2'b01, 3'b111, 3'b011);
      sec(IACD_CMD_VS, 2'b00, 3'b111, 3'b000);
      sec(IACD_CMD_VS, 2'b10, 3'b001, 3'b001);
      // continuous listening
      cmd(IACD_CMD_LTNC);
      check(cont_mode, 1'b1);
      t = rdy_cnt;
      rx(1'b0);
      check(rdy_cnt - t, 32'h0000_0001);
      check({data_in_flag, rfd_hold}, 2'b00);
      t = rdy_cnt;
      rx(1'b1);
      check({rdy_cnt == t, rfd_hold}, 2'b11);
      @(posedge ref_clk);
      unlisten <= 1'b1;
      @(posedge ref_clk);
      unlisten <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 check({cont_mode, rfd_hold}, 2'b00);
      rx(1'b0);
      check(data_in_flag, 1'b1);
      // continuous listen issued while idle must survive the idle level
      cmd(IACD_CMD_LTNC);
      @(posedge ref_clk);
      #1 check(cont_mode, 1'b1);
      close_out();
   end
endmodule
`default_nettype wire
